/* shared/drc_regs.vh */
`ifndef DRC_REGS_VH
`define DRC_REGS_VH
// Refresh low time: code 0..3 maps to 2..5 clocks
`define DRC_LOW_BASE        3'h2
// Precharge guard in clocks
`define DRC_PRECHARGE       3'h2
// Refresh period unit in clocks per period-bits step
`define DRC_PERIOD_UNIT     12'h100
// Strobe config codes
`define DRC_CFG_SINGLE      3'h0
`define DRC_CFG_PAIR        3'h1
// Refresh row address width at mem_addr_out; the row counter rf_addr is 22 bits
`define DRC_ROW_BITS        11
`endif

/* rtl/drc_sync.v */
`default_nettype none
module drc_sync
(
   // Clock and reset
   input  wire core_clk,
   input  wire rst_n,
   // Async in, synced out
   input  wire d,
   output reg  q
);
   reg meta;
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

/* rtl/drc_timer.v */
`include "drc_regs.vh"
`default_nettype none
module drc_timer
(
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst_n,
   // Period select and tick
   input  wire [3:0] period_bits,
   output reg        tick
);
   reg  [15:0] count;
   wire [15:0] limit;
   assign limit = {4'h0, `DRC_PERIOD_UNIT} * ({12'h000, period_bits} + 16'h0001);
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end
      else if (count >= limit - 16'h0001)
      begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* rtl/drc_refresh.v */
`include "drc_regs.vh"
`default_nettype none
module drc_refresh
(
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst_n,
   // Programming bits
   input  wire [1:0]  refresh_low_time_bits,
   input  wire [3:0]  refresh_period_bits,
   input  wire [2:0]  strobe_config_bits,
   input  wire        stagger_select_bit,
   input  wire        write_col_delay_bit,
   input  wire        extended_col_strobe_mode,
   input  wire        pipeline_mode,
   // Pins from outside
   input  wire        ext_refresh_req_n,
   input  wire        auto_refresh_disable_n,
   input  wire        refresh_extend,
   input  wire        port_a_access_hold_n,
   input  wire        port_b_access_hold_n,
   input  wire        write_request_in_n,
   input  wire        col_strobe_enable_in_n,
   // Access side from the controller core
   input  wire        access_start,
   input  wire        access_write_en_in,
   // Memory outputs
   output reg  [3:0]  row_strobe_n,
   output reg         col_strobe_n,
   output reg         refresh_in_progress_n,
   output reg         write_en_out_n,
   output reg  [10:0] mem_addr_out,
   output reg         access_in_progress
);
   localparam ST_IDLE = 5'h01;
   localparam ST_ARM  = 5'h02;
   localparam ST_LOW  = 5'h04;
   localparam ST_PRE  = 5'h08;
   localparam ST_ACC  = 5'h10;

   wire ext_refresh_req_s;
   wire dis_s;
   wire ext_s;
   wire hold_a_s;
   wire hold_b_s;
   wire win_s;
   wire col_strobe_enable_in_s;
   wire tick;

   drc_sync u_s0 (.core_clk(core_clk), .rst_n(rst_n), .d(~ext_refresh_req_n), .q(ext_refresh_req_s));
   drc_sync u_s1 (.core_clk(core_clk), .rst_n(rst_n), .d(~auto_refresh_disable_n), .q(dis_s));
   drc_sync u_s2 (.core_clk(core_clk), .rst_n(rst_n), .d(refresh_extend), .q(ext_s));
   drc_sync u_s3 (.core_clk(core_clk), .rst_n(rst_n), .d(~port_a_access_hold_n), .q(hold_a_s));
   drc_sync u_s4 (.core_clk(core_clk), .rst_n(rst_n), .d(~port_b_access_hold_n), .q(hold_b_s));
   drc_sync u_s5 (.core_clk(core_clk), .rst_n(rst_n), .d(~write_request_in_n), .q(win_s));
   drc_sync u_s6 (.core_clk(core_clk), .rst_n(rst_n), .d(~col_strobe_enable_in_n), .q(col_strobe_enable_in_s));

   drc_timer u_tmr
   (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .period_bits (refresh_period_bits),
      .tick        (tick)
   );

   reg  [4:0]  state;
   reg  [2:0]  cnt;
   reg  [3:0]  age;
   reg  [3:0]  on_grp;
   reg  [3:0]  stag_pat;
   reg  [3:0]  first_mask;
   reg         ext_latch;
   reg         tmr_pend;
   reg         ext_refresh_req_d;
   reg  [21:0] rf_addr;
   reg         rq_toggle;
   reg         acc_row;
   reg         acc_wr;

   wire [2:0]  low_clocks;
   wire        acc_hold;
   wire        auto_ok;
   wire        want;
   wire        rq_mode;
   wire        staggered;
   wire        ext_refresh_req_fall;
   wire [3:0]  age_l;
   wire        stag_done;
   wire [2:0]  last_step;

   assign low_clocks = `DRC_LOW_BASE + {1'b0, refresh_low_time_bits};
   assign acc_hold   = hold_a_s | hold_b_s;
   assign auto_ok    = tmr_pend & ~dis_s;
   assign want       = ext_latch | auto_ok;
   assign rq_mode    = extended_col_strobe_mode | pipeline_mode;
   assign staggered  = stagger_select_bit;
   assign ext_refresh_req_fall  = ext_refresh_req_s & ~ext_refresh_req_d;
   // Stagger: single steps 4, pairs 2, all 1
   assign last_step  = !staggered ? 3'h0 :
                       (strobe_config_bits == `DRC_CFG_SINGLE) ? 3'h3 :
                       (strobe_config_bits == `DRC_CFG_PAIR)   ? 3'h1 : 3'h0;
   assign age_l      = {1'b0, low_clocks};
   // All groups have met their low time once the last one has
   assign stag_done  = age >= ({1'b0, last_step} + age_l);

   // Which groups are low at the current age of the refresh
   always @*
   begin
      on_grp = 4'h0;
      if (age < age_l)
      begin
         on_grp[0] = 1'b1;
      end
      if ((age >= 4'h1) && (age < age_l + 4'h1))
      begin
         on_grp[1] = 1'b1;
      end
      if ((age >= 4'h2) && (age < age_l + 4'h2))
      begin
         on_grp[2] = 1'b1;
      end
      if ((age >= 4'h3) && (age < age_l + 4'h3))
      begin
         on_grp[3] = 1'b1;
      end
   end

   // Group to strobe mapping; each group keeps its own low time
   always @*
   begin
      stag_pat   = 4'h0;
      first_mask = 4'hF;
      case (last_step)
         3'h3:
         begin
            stag_pat   = on_grp;
            first_mask = 4'h1;
         end
         3'h1:
         begin
            stag_pat   = {on_grp[1], on_grp[1], on_grp[0], on_grp[0]};
            first_mask = 4'h3;
         end
         default:
         begin
            stag_pat   = {4{on_grp[0]}};
            first_mask = 4'hF;
         end
      endcase
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state                 <= ST_IDLE;
         cnt                   <= 3'h0;
         age                   <= 4'h0;
         ext_latch             <= 1'b0;
         tmr_pend              <= 1'b0;
         ext_refresh_req_d                <= 1'b0;
         rf_addr               <= 22'h000000;
         rq_toggle             <= 1'b0;
         acc_row               <= 1'b0;
         acc_wr                <= 1'b0;
         row_strobe_n          <= 4'hF;
         col_strobe_n          <= 1'b1;
         refresh_in_progress_n <= 1'b1;
         write_en_out_n        <= 1'b1;
         mem_addr_out          <= 11'h000;
         access_in_progress    <= 1'b0;
      end
      else
      begin
         ext_refresh_req_d <= ext_refresh_req_s;
         if (ext_refresh_req_fall)
            ext_latch <= 1'b1;
         if (tick)
            tmr_pend <= 1'b1;
         if (ext_refresh_req_s && !dis_s)
            rf_addr <= 22'h000000;
         // Request output with missed-period toggle
         if (tick && tmr_pend && state != ST_LOW)
            rq_toggle <= 1'b1;
         else
            rq_toggle <= 1'b0;
         if (rq_mode)
            write_en_out_n <= ~((tmr_pend | ext_latch) & ~rq_toggle
                                & ~(tick & tmr_pend));
         else
            write_en_out_n <= ~(acc_row & acc_wr & ~refresh_in_progress_n);
         case (state)
            ST_IDLE:
            begin
               if (want && !acc_hold && !access_start)
               begin
                  refresh_in_progress_n <= 1'b0;
                  state                 <= ST_ARM;
               end
               else if (access_start)
               begin
                  acc_row            <= 1'b1;
                  acc_wr             <= access_write_en_in & win_s;
                  access_in_progress <= 1'b1;
                  row_strobe_n       <= 4'h0;
                  // Column follows row when its enable is in, unless write delay applies
                  col_strobe_n <= (write_col_delay_bit & win_s) | ~col_strobe_enable_in_s;
                  state        <= ST_ACC;
               end
            end
            ST_ACC:
            begin
               col_strobe_n <= ~col_strobe_enable_in_s;
               if (!acc_hold)
               begin
                  row_strobe_n       <= 4'hF;
                  col_strobe_n       <= 1'b1;
                  acc_row            <= 1'b0;
                  access_in_progress <= 1'b0;
                  cnt                <= 3'h0;
                  state              <= ST_PRE;
               end
            end
            ST_ARM:
            begin
               row_strobe_n          <= ~first_mask;
               mem_addr_out          <= rf_addr[10:0];
               age                   <= 4'h1;
               state                 <= ST_LOW;
            end
            ST_LOW:
            begin
               if (!stag_done)
               begin
                  // Successive groups start one edge apart
                  row_strobe_n <= ~stag_pat;
                  age          <= age + 4'h1;
               end
               else if (ext_s && !staggered)
                  age <= age;
               else
               begin
                  row_strobe_n          <= 4'hF;
                  refresh_in_progress_n <= 1'b1;
                  rf_addr               <= rf_addr + 22'h000001;
                  mem_addr_out          <= rf_addr[10:0] + 11'h001;
                  ext_latch             <= ext_refresh_req_fall;
                  tmr_pend              <= tick;
                  cnt                   <= 3'h0;
                  state                 <= ST_PRE;
               end
            end
            ST_PRE:
            begin
               if (cnt >= `DRC_PRECHARGE - 3'h1)
               begin
                  if (ext_refresh_req_s && dis_s)
                     ext_latch <= 1'b1;
                  state <= ST_IDLE;
               end
               else
                  cnt <= cnt + 3'h1;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* tb/drc_refresh_checker.sv */
`include "drc_regs.vh"
`default_nettype none
module drc_chk
(
   // Clock, reset, setup
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [1:0]  refresh_low_time_bits,
   input wire logic [2:0]  strobe_config_bits,
   input wire logic        stagger_select_bit,
   // Memory side
   input wire logic [3:0]  row_strobe_n,
   input wire logic        refresh_in_progress_n,
   input wire logic [10:0] mem_addr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] low_cnt;
   // Cycles with refresh strobe 0 low
   always @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         low_cnt <= 4'h0;
      else
         low_cnt <= (!row_strobe_n[0] && !refresh_in_progress_n) ? low_cnt + 4'h1 : 4'h0;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_refresh_in_progress_lead: assert property ($fell(refresh_in_progress_n) |=> !row_strobe_n[0])
      else $error("no strobe after refresh flag");
   a_low_time: assert property ($rose(row_strobe_n[0]) && !$past(refresh_in_progress_n)
      |-> low_cnt == {2'h0, refresh_low_time_bits} + 4'h2) else $error("bad low time");
   a_addr_step: assert property ($rose(refresh_in_progress_n)
      |-> mem_addr_out == $past(mem_addr_out) + 11'h1) else $error("row count not stepped");
   a_conv_start: assert property (!stagger_select_bit && $fell(row_strobe_n[0])
      && !refresh_in_progress_n |-> row_strobe_n == 4'h0) else $error("strobes apart");
   a_conv_end: assert property (!stagger_select_bit && $rose(row_strobe_n[0])
      && !$past(refresh_in_progress_n) |-> refresh_in_progress_n && row_strobe_n == 4'hF)
      else $error("strobes and flag not ended together");
   a_stag_single: assert property (stagger_select_bit
      && strobe_config_bits == `DRC_CFG_SINGLE && $fell(row_strobe_n[0])
      && !refresh_in_progress_n
      |=> $fell(row_strobe_n[1]) ##1 $fell(row_strobe_n[2]) ##1 $fell(row_strobe_n[3]))
      else $error("single stagger out of step");
   a_stag_pair: assert property (stagger_select_bit
      && strobe_config_bits == `DRC_CFG_PAIR && $fell(row_strobe_n[0])
      && !refresh_in_progress_n |-> !row_strobe_n[1] ##1 $fell(row_strobe_n[2])
      && !row_strobe_n[3]) else $error("pair stagger out of step");
   a_precharge: assert property ($rose(row_strobe_n[3]) |-> row_strobe_n[3] [*2])
      else $error("precharge too short");
   c_refresh: cover property ($fell(refresh_in_progress_n));
   c_stagger: cover property (stagger_select_bit && $fell(row_strobe_n[3]));
   c_burst: cover property ($rose(refresh_in_progress_n) ##[1:8] $fell(refresh_in_progress_n));
endmodule
bind drc_refresh drc_chk u_chk
(
   .core_clk(core_clk), .rst_n(rst_n), .refresh_low_time_bits(refresh_low_time_bits),
   .strobe_config_bits(strobe_config_bits), .stagger_select_bit(stagger_select_bit),
   .row_strobe_n(row_strobe_n), .refresh_in_progress_n(refresh_in_progress_n),
   .mem_addr_out(mem_addr_out)
);
`default_nettype wire

/* tb/drc_ext_ctl.sv */
`default_nettype none
module drc_ext_ctl
(
   // Clock and bench commands
   input wire logic  core_clk,
   input wire logic  take_over,
   input wire logic  pulse,
   // Request pins
   output var logic  auto_refresh_disable_n,
   output var logic  ext_refresh_req_n
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      auto_refresh_disable_n = 1'b1;
      ext_refresh_req_n = 1'b1;
   end
   // Requests only once auto refresh is already off
   always @(negedge core_clk)
   begin
      auto_refresh_disable_n <= !take_over;
      ext_refresh_req_n <= !(pulse && take_over && !auto_refresh_disable_n);
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`include "drc_regs.vh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0, rst_n = 1'b0, take_over = 1'b0, pulse = 1'b0;
   logic [1:0]  refresh_low_time_bits = 2'h1;
   logic [3:0]  refresh_period_bits = 4'h0;
   logic [2:0]  strobe_config_bits = 3'h2;
   logic        stagger_select_bit = 1'b0, extended_col_strobe_mode = 1'b0;
   logic        port_a_access_hold_n = 1'b1, write_request_in_n = 1'b1;
   logic        access_start = 1'b0, access_write_en_in = 1'b0;
   wire         auto_refresh_disable_n, ext_refresh_req_n, col_strobe_n;
   wire         refresh_in_progress_n, write_en_out_n, access_in_progress;
   wire  [3:0]  row_strobe_n;
   wire  [10:0] mem_addr_out;
   int          fail_count = 0, n_tests = 0, n, k;
   always #4 core_clk = ~core_clk;
   drc_ext_ctl u_ext
   (
      .core_clk(core_clk), .take_over(take_over), .pulse(pulse),
      .auto_refresh_disable_n(auto_refresh_disable_n), .ext_refresh_req_n(ext_refresh_req_n)
   );
   drc_refresh dut
   (
      .core_clk(core_clk), .rst_n(rst_n), .refresh_low_time_bits(refresh_low_time_bits),
      .refresh_period_bits(refresh_period_bits), .strobe_config_bits(strobe_config_bits),
      .stagger_select_bit(stagger_select_bit), .write_col_delay_bit(1'b0),
      .extended_col_strobe_mode(extended_col_strobe_mode), .pipeline_mode(1'b0),
      .ext_refresh_req_n(ext_refresh_req_n), .auto_refresh_disable_n(auto_refresh_disable_n),
      .refresh_extend(1'b0), .port_a_access_hold_n(port_a_access_hold_n),
      .port_b_access_hold_n(1'b1), .write_request_in_n(write_request_in_n),
      .col_strobe_enable_in_n(1'b1), .access_start(access_start),
      .access_write_en_in(access_write_en_in), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .refresh_in_progress_n(refresh_in_progress_n),
      .write_en_out_n(write_en_out_n), .mem_addr_out(mem_addr_out),
      .access_in_progress(access_in_progress)
   );
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_refresh_in_progress(input int lim);
      n = 0;
      @(negedge core_clk);
      while (refresh_in_progress_n !== 1'b0 && n < lim)
      begin
         n++;
         @(negedge core_clk);
      end
   endtask
   // Conventional cycle, entered just as the flag drops
   task automatic t_conv(input logic [10:0] a0);
      chk({7'h0, row_strobe_n}, 11'hF);
      @(negedge core_clk);
      chk({7'h0, row_strobe_n}, 11'h0);
      repeat (2 + refresh_low_time_bits) @(negedge core_clk);
      chk({6'h0, refresh_in_progress_n, row_strobe_n}, 11'h1F);
      chk(mem_addr_out, a0 + 11'h1);
   endtask
   task automatic t_pulse();
      pulse <= 1'b1;
      repeat (2) @(negedge core_clk);
      pulse <= 1'b0;
      wait_refresh_in_progress(30);
      chk(11'(n < 30), 11'h1);
   endtask
   task automatic t_auto();
      wait_refresh_in_progress(600);
      t_conv(mem_addr_out);
      wait_refresh_in_progress(600);
      chk(11'(n), 11'(`DRC_PERIOD_UNIT - 4 - refresh_low_time_bits));
      t_conv(mem_addr_out);
   endtask
   task automatic t_ext();
      logic [10:0] a0;
      take_over <= 1'b1;
      repeat (3) @(negedge core_clk);
      t_pulse();
      t_conv(mem_addr_out);
      a0 = mem_addr_out;
      k = 0;
      pulse <= 1'b1;
      repeat (60)
      begin
         @(negedge core_clk);
         k += (refresh_in_progress_n === 1'b0 && row_strobe_n === 4'hF);
         if (n_tests > 0 && k == 5)
            pulse <= 1'b0;
      end
      chk(11'(k), 11'h5);
      chk(mem_addr_out - a0, 11'h5);
   endtask
   task automatic t_access();
      port_a_access_hold_n = 1'b0;
      write_request_in_n = 1'b0;
      access_write_en_in = 1'b1;
      // Let the hold pass its synchroniser before the access starts
      repeat (3) @(negedge core_clk);
      access_start = 1'b1;
      @(negedge core_clk);
      access_start = 1'b0;
      t_pulse_hold();
   endtask
   task automatic t_pulse_hold();
      pulse <= 1'b1;
      repeat (10) @(negedge core_clk);
      pulse <= 1'b0;
      chk({9'h0, access_in_progress, refresh_in_progress_n}, 11'h3);
      port_a_access_hold_n = 1'b1;
      write_request_in_n = 1'b1;
      wait_refresh_in_progress(30);
      chk(11'(n < 30), 11'h1);
      repeat (20) @(negedge core_clk);
   endtask
   task automatic t_stag();
      logic [3:0] exp [3] = '{4'hE, 4'hC, 4'h0};
      stagger_select_bit = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         strobe_config_bits = 3'(i);
         t_pulse();
         @(negedge core_clk);
         chk({7'h0, row_strobe_n}, {7'h0, exp[i]});
         repeat (20) @(negedge core_clk);
      end
   endtask
   task automatic t_req();
      extended_col_strobe_mode = 1'b1;
      k = 0;
      for (n = 0; n < 600 && write_en_out_n !== 1'b0; n++)
      begin
         @(negedge core_clk);
         k += (refresh_in_progress_n === 1'b0);
      end
      chk(11'(n < 600), 11'h1);
      chk(11'(k), 11'h0);
      repeat (20) @(negedge core_clk);
      chk({9'h0, write_en_out_n, refresh_in_progress_n}, 11'h1);
      t_pulse();
      repeat (12) @(negedge core_clk);
      chk({10'h0, write_en_out_n}, 11'h1);
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #(20000 * 8);
      fail_count++;
      results();
   end
   initial
   begin
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      chk({mem_addr_out[6:0], refresh_in_progress_n, row_strobe_n[2:0]}, 11'hF);
      t_auto();
      t_ext();
      t_access();
      t_stag();
      t_req();
      results();
   end
endmodule
`default_nettype wire
